/* File: hdl/dsmod_pkg.sv */
// Constants for the data signal modulator
// Functional notes
// - Modulated output appears only while software holds the enable bit set.
// - Clearing enable stops output; selections are kept and reused on re-enable.
// - While disabled, the modulated output pin is held at logic low.
// - Data high mixes the upper carrier; data low mixes the lower carrier.
// - 5-bit data selector: pin, software bit, peripherals, logic cells, reserved.
// - 4-bit upper carrier selector: pin, clocks, peripherals, logic cells.
// - Lower carrier selector uses the same code map as the upper one.
// - With sync on, the active carrier finishes its pulse before switching.
// - Separate sync enables for leaving the upper and leaving the lower carrier.
// - With sync off, carriers switch at once, even truncating a pulse.
// - Each selected carrier has its own invert bit applied before mixing.
// - Output invert bit flips the modulated output so it idles high.
// - Any reset disables the block and restores all registers to defaults.
// - A read-only status bit shows the modulated output value, synchronised through two flops.
package dsmod_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int REG_ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL0 = 12'hf4c; // mixer_control_zero
  localparam logic [11:0] ADDR_CTRL1 = 12'hf4d;
  localparam logic [11:0] ADDR_SRC = 12'hf4e;
  localparam logic [11:0] ADDR_LCAR = 12'hf4f;
  localparam logic [11:0] ADDR_UCAR = 12'hf50;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL0_EN_POS = 7;
  localparam int CTRL0_OUT_POS = 5;
  localparam int CTRL0_OINV_POS = 4;
  localparam int CTRL0_SWBIT_POS = 0;
  localparam int CTRL1_UINV_POS = 5;
  localparam int CTRL1_USYNC_POS = 4;
  localparam int CTRL1_LINV_POS = 1;
  localparam int CTRL1_LSYNC_POS = 0;
  localparam int DATA_SEL_W = 5;
  localparam int CAR_SEL_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic [4:0] RST_DATA_SEL = 5'h00;
  localparam logic [3:0] RST_CAR_SEL = 4'h0;

  // Widths of the source groups
  localparam int DATA_PERIPH_N = 12;
  localparam int CAR_PERIPH_N = 4;
  localparam int LCELL_N = 8;

endpackage

/* File: hdl/dsmod_src_mux.sv */
// Source selector: picks one input by code, empty slots tied low upstream
`timescale 1ns/1ps
module dsmod_src_mux #(
  parameter int SEL_W = 4
) (
  // Candidate sources, one bit per code
  input wire logic [(2**SEL_W)-1:0] src_i,
  // Code
  input wire logic [SEL_W-1:0] sel_i,
  // Chosen source
  output logic y_o
);

  // Pure combinational path so fast carriers pass untouched
  assign y_o = src_i[sel_i];

endmodule

/* File: hdl/dsmod_sync2.sv */
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module dsmod_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule

/* File: hdl/dsmod_top.sv */
// Data signal modulator: registers, source selection, carrier mixing
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module dsmod_top
  import dsmod_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [REG_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Data stream sources
  input wire logic data_stream_pin_i,
  input wire logic [DATA_PERIPH_N-1:0] data_periph_i,
  // Carrier sources
  input wire logic upper_carrier_pin_i,
  input wire logic lower_carrier_pin_i,
  input wire logic internal_fast_oscillator_i,
  input wire logic reference_clock_output_i,
  input wire logic [CAR_PERIPH_N-1:0] carrier_periph_i,
  // Shared logic cell outputs
  input wire logic [LCELL_N-1:0] logic_cell_output_i,
  // Modulated output, to the output pin route
  output logic modulated_output_pin_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic enable_r;
  logic output_invert_r;
  logic software_data_bit_r;
  logic upper_carrier_invert_r;
  logic upper_carrier_sync_enable_r;
  logic lower_carrier_invert_r;
  logic lower_carrier_sync_enable_r;
  logic [DATA_SEL_W-1:0] data_stream_source_select_r;
  logic [CAR_SEL_W-1:0] lower_carrier_choice_r;
  logic [CAR_SEL_W-1:0] upper_carrier_choice_r;
  logic [7:0] rdata_r;
  logic upper_active_r;
  logic upper_active_nxt;

  // Write decode
  wire logic wr_ctrl0 = wr_i && (addr_i == ADDR_CTRL0);
  wire logic wr_ctrl1 = wr_i && (addr_i == ADDR_CTRL1);
  wire logic wr_src = wr_i && (addr_i == ADDR_SRC);
  wire logic wr_lcar = wr_i && (addr_i == ADDR_LCAR);
  wire logic wr_ucar = wr_i && (addr_i == ADDR_UCAR);

  // Control 0: enable, output invert, software data bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_r <= RST_BIT;
      output_invert_r <= RST_BIT;
      software_data_bit_r <= RST_BIT;
    end else if (wr_ctrl0) begin
      enable_r <= wdata_i[CTRL0_EN_POS];
      output_invert_r <= wdata_i[CTRL0_OINV_POS];
      software_data_bit_r <= wdata_i[CTRL0_SWBIT_POS];
    end
  end

  // Control 1: per-carrier invert and sync enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_carrier_invert_r <= RST_BIT;
      upper_carrier_sync_enable_r <= RST_BIT;
      lower_carrier_invert_r <= RST_BIT;
      lower_carrier_sync_enable_r <= RST_BIT;
    end else if (wr_ctrl1) begin
      upper_carrier_invert_r <= wdata_i[CTRL1_UINV_POS];
      upper_carrier_sync_enable_r <= wdata_i[CTRL1_USYNC_POS];
      lower_carrier_invert_r <= wdata_i[CTRL1_LINV_POS];
      lower_carrier_sync_enable_r <= wdata_i[CTRL1_LSYNC_POS];
    end
  end

  // Selections; enable writes never touch them, so they survive a disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_stream_source_select_r <= RST_DATA_SEL;
      lower_carrier_choice_r <= RST_CAR_SEL;
      upper_carrier_choice_r <= RST_CAR_SEL;
    end else begin
      if (wr_src) begin
        data_stream_source_select_r <= wdata_i[DATA_SEL_W-1:0];
      end
      if (wr_lcar) begin
        lower_carrier_choice_r <= wdata_i[CAR_SEL_W-1:0];
      end
      if (wr_ucar) begin
        upper_carrier_choice_r <= wdata_i[CAR_SEL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source tables; reserved data codes read as constant low
  wire logic [(2**DATA_SEL_W)-1:0] data_data_stream_source_select = {
    8'h00,                     // 11000-11111 reserved
    logic_cell_output_i,       // 10000-10111
    2'b00,                     // 01110, 01111 reserved
    data_periph_i,             // 00010-01101
    software_data_bit_r,       // 00001
    data_stream_pin_i          // 00000
  };

  // System clock is a carrier source in its own right
  wire logic [(2**CAR_SEL_W)-1:0] car_data_stream_source_select_upper = {
    logic_cell_output_i, carrier_periph_i, reference_clock_output_i,
    internal_fast_oscillator_i, clk_i, upper_carrier_pin_i
  };
  wire logic [(2**CAR_SEL_W)-1:0] car_data_stream_source_select_lower = {
    logic_cell_output_i, carrier_periph_i, reference_clock_output_i,
    internal_fast_oscillator_i, clk_i, lower_carrier_pin_i
  };

  logic data_raw;
  logic upper_raw;
  logic lower_raw;

  dsmod_src_mux #(
    .SEL_W(DATA_SEL_W)
  ) u_data_mux (
    .src_i(data_data_stream_source_select),
    .sel_i(data_stream_source_select_r),
    .y_o(data_raw)
  );

  dsmod_src_mux #(
    .SEL_W(CAR_SEL_W)
  ) u_upper_mux (
    .src_i(car_data_stream_source_select_upper),
    .sel_i(upper_carrier_choice_r),
    .y_o(upper_raw)
  );

  dsmod_src_mux #(
    .SEL_W(CAR_SEL_W)
  ) u_lower_mux (
    .src_i(car_data_stream_source_select_lower),
    .sel_i(lower_carrier_choice_r),
    .y_o(lower_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Carrier polarity and mixing, all combinational
  wire logic upper_car = upper_raw ^ upper_carrier_invert_r;
  wire logic lower_car = lower_raw ^ lower_carrier_invert_r;

  // Sampled copies steer the switchover and the status bit, never the mixed path
  logic [3:0] samp;
  logic mix_out;

  dsmod_sync2 #(
    .W(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({mix_out, lower_car, upper_car, data_raw}),
    .q_o(samp)
  );

  wire logic data_s = samp[0];
  wire logic upper_s = samp[1];
  wire logic lower_s = samp[2];
  wire logic out_s = samp[3];

  // Sync setting of the carrier currently in use
  wire logic active_sync = upper_active_r ? upper_carrier_sync_enable_r
                                          : lower_carrier_sync_enable_r;
  wire logic active_car_s = upper_active_r ? upper_s : lower_s;

  // Without sync the data stream picks the carrier directly
  wire logic use_upper = active_sync ? upper_active_r : data_raw;

  // Held carrier may move only once its pulse is seen low; two-cycle
  // sampling latency means a carrier above a quarter of clk may slip
  assign upper_active_nxt = (!active_sync || !active_car_s) ? data_s
                                                            : upper_active_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_active_r <= RST_BIT;
    end else begin
      upper_active_r <= upper_active_nxt;
    end
  end

  // Mixed stream; held low while disabled regardless of inversion
  assign mix_out = enable_r &
                   ((use_upper ? upper_car : lower_car) ^ output_invert_r);
  // Tags above: on the selection and inversion term

  // Direct drive keeps carriers faster than clk intact
  assign modulated_output_pin_o = mix_out;

  ////////////////////////////////////////////////////////////////////////////
  // Read back; status bit is the synchronised output
  wire logic [7:0] rd_ctrl0 = {enable_r, 1'b0, out_s, output_invert_r,
                               3'b000, software_data_bit_r};
  wire logic [7:0] rd_ctrl1 = {2'b00, upper_carrier_invert_r,
                               upper_carrier_sync_enable_r, 2'b00,
                               lower_carrier_invert_r,
                               lower_carrier_sync_enable_r};
  wire logic [7:0] rd_word =
    (addr_i == ADDR_CTRL0) ? rd_ctrl0 :
    (addr_i == ADDR_CTRL1) ? rd_ctrl1 :
    (addr_i == ADDR_SRC) ? {3'b000, data_stream_source_select_r} :
    (addr_i == ADDR_LCAR) ? {4'h0, lower_carrier_choice_r} :
    (addr_i == ADDR_UCAR) ? {4'h0, upper_carrier_choice_r} :
    8'h00;

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_i ? rd_word : 8'h00;
    end
  end

  assign rdata_o = rdata_r;

endmodule

/* File: sim/dsmod_properties.sv */
// Concurrent checks on the modulator ports
`timescale 1ns/1ps
module dsmod_properties
  import dsmod_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [REG_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Carrier pins and output
  input wire logic upper_carrier_pin_i,
  input wire logic lower_carrier_pin_i,
  input wire logic modulated_output_pin_o
);
  logic [7:0] c0_r, c1_r, src_r, lcar_r, ucar_r;
  wire out = modulated_output_pin_o;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the writable fields; reserved bits masked as the block reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      src_r <= 8'h00;
      lcar_r <= 8'h00;
      ucar_r <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == ADDR_CTRL0) c0_r <= wdata_i & 8'h91;
      if (addr_i == ADDR_CTRL1) c1_r <= wdata_i & 8'h33;
      if (addr_i == ADDR_SRC) src_r <= wdata_i & 8'h1f;
      if (addr_i == ADDR_LCAR) lcar_r <= wdata_i & 8'h0f;
      if (addr_i == ADDR_UCAR) ucar_r <= wdata_i & 8'h0f;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Properties; direct mixing only judged with both sync bits clear
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_dis_low: assert property (!c0_r[7] |-> !out)
    else $error("output not low while disabled");
  a_rst_off: assert property ($past(rst_i) |->
    !out && rdata_o == 8'h00) else $error("state not cleared by reset");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_ctrl0_read: assert property (rd_i && addr_i == ADDR_CTRL0 |=>
    rdata_o == {$past(c0_r[7]), 1'b0, $past(out, 3), $past(c0_r[4]), 3'h0,
    $past(c0_r[0])}) else $error("control zero readback wrong");
  a_ctrl1_read: assert property (rd_i && addr_i == ADDR_CTRL1 |=>
    rdata_o == $past(c1_r)) else $error("control one readback wrong");
  a_src_read: assert property (rd_i && addr_i == ADDR_SRC |=>
    rdata_o == $past(src_r)) else $error("data select readback wrong");
  a_lcar_read: assert property (rd_i && addr_i == ADDR_LCAR |=>
    rdata_o == $past(lcar_r)) else $error("lower select readback wrong");
  a_ucar_read: assert property (rd_i && addr_i == ADDR_UCAR |=>
    rdata_o == $past(ucar_r)) else $error("upper select readback wrong");
  a_mix_direct: assert property (c0_r[7] && (c1_r & 8'h11) == 8'h00 &&
    src_r == 8'h01 && ucar_r == 8'h00 && lcar_r == 8'h00 |-> out ==
    ((c0_r[0] ? upper_carrier_pin_i ^ c1_r[5] : lower_carrier_pin_i ^
    c1_r[1]) ^ c0_r[4])) else $error("direct mixing wrong");
  a_rsv_low: assert property (c0_r[7] && (c1_r & 8'h11) == 8'h00 &&
    (src_r >= 8'h18 || src_r[4:1] == 4'h7) && lcar_r == 8'h00 |->
    out == (lower_carrier_pin_i ^ c1_r[1] ^ c0_r[4]))
    else $error("reserved data code not low");
  c_usync: cover property (c0_r[7] && c1_r[4] && !c0_r[0]);
  c_rsv: cover property (c0_r[7] && src_r >= 8'h18 && lcar_r == 8'h00);
  c_lsync: cover property (c0_r[7] && c1_r[0] && c0_r[0]);
  c_status: cover property (rd_i && addr_i == ADDR_CTRL0 && out);
endmodule

bind dsmod_top dsmod_properties dsmod_properties_i (
  .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .upper_carrier_pin_i, .lower_carrier_pin_i, .modulated_output_pin_o
);

/* File: sim/dsmod_src_model.sv */
// Model of the peripherals and pins feeding data and carriers
`timescale 1ns/1ps
module dsmod_src_model
  import dsmod_pkg::*;
(
  // Clock and steering
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic upper_i,
  // Sources
  output logic [28:0] src_o
);
  logic [31:0] rnd;
  logic [28:0] src_r = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Sources change every cycle; hold freezes them so a scenario can steer
  // both carrier pins (bits 15 and 14) together by hand
  always @(posedge clk_i) begin
    rnd = $urandom;
    if (hold_i) src_r[15:14] <= {2{upper_i}};
    else src_r <= rnd[28:0];
  end
  assign src_o = src_r;
endmodule

/* File: sim/dsmod_top_tb.sv */
// Self-checking bench for the data signal modulator
`timescale 1ns/1ps
module dsmod_top_tb;
  import dsmod_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [REG_ADDR_W-1:0] addr_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic hold = 1'b0;
  logic cu = 1'b0;
  logic [7:0] rdata_o;
  logic [28:0] s;
  logic out;
  logic [7:0] sh [5] = '{default: 8'h00};
  logic [7:0] msk [5] = '{8'h91, 8'h33, 8'h1f, 8'h0f, 8'h0f};
  int err_count = 0;
  int tests_run = 0;
  int seed_v;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and source model
  always #10 clk_i = ~clk_i;
  dsmod_top dsmod_top_i (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .data_stream_pin_i(s[28]), .data_periph_i(s[27:16]),
    .upper_carrier_pin_i(s[15]), .lower_carrier_pin_i(s[14]),
    .internal_fast_oscillator_i(s[13]), .reference_clock_output_i(s[12]),
    .carrier_periph_i(s[11:8]), .logic_cell_output_i(s[7:0]),
    .modulated_output_pin_o(out));
  dsmod_src_model dsmod_src_model_i (.clk_i, .hold_i(hold), .upper_i(cu),
    .src_o(s));
  ////////////////////////////////////////////////////////////////////////////
  // Reference model and bus tasks
  function automatic logic car(logic [7:0] c, logic p);
    if (c < 2) return c[0] ? clk_i : p;
    if (c < 4) return s[15 - c];
    return c < 8 ? s[c + 4] : s[c - 8];
  endfunction
  function automatic logic expo();
    int k;
    logic d;
    k = sh[2];
    d = 1'b0;
    if (k < 2) d = k ? sh[0][0] : s[28];
    else if (k < 14) d = s[k + 14];
    else if (k >= 16 && k < 24) d = s[k - 16];
    if (d) return sh[0][7] & (car(sh[4], s[15]) ^ sh[1][5] ^ sh[0][4]);
    return sh[0][7] & (car(sh[3], s[14]) ^ sh[1][1] ^ sh[0][4]);
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a >= ADDR_CTRL0 && a <= ADDR_UCAR) begin
      sh[a - ADDR_CTRL0] = d & msk[a - ADDR_CTRL0];
    end
    #1;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e, string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, rdata_o, e);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog, several times the expected run length
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed_v = $urandom(24);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(12'(ADDR_CTRL0 + i), 8'h00, "reset");
    end
    wr(12'hf51, 8'hff);
    rd(12'hf51, 8'h00, "unmapped");
    for (int i = 0; i < 150; i++) begin
      wr(ADDR_CTRL1, 8'($urandom) & 8'hee);
      wr(ADDR_SRC, 8'($urandom));
      wr(ADDR_LCAR, i < 40 ? 8'h00 : 8'($urandom));
      wr(ADDR_UCAR, 8'($urandom));
      wr(ADDR_CTRL0, 8'($urandom));
      rd(ADDR_SRC, sh[2], "src");
      rd(ADDR_LCAR, sh[3], "lcar");
      rd(ADDR_UCAR, sh[4], "ucar");
      for (int j = 0; j < 3; j++) begin
        chk("mix", {7'h0, out}, {7'h0, expo()});
        @(posedge clk_i);
        #1;
      end
    end
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_SRC, 8'h01);
    wr(ADDR_UCAR, 8'h00);
    wr(ADDR_LCAR, 8'h00);
    @(posedge clk_i);
    hold <= 1'b1;
    cu <= 1'b1;
    wr(ADDR_CTRL0, 8'h91);
    chk("oinv", {7'h0, out}, {7'h0, expo()});
    wr(ADDR_CTRL1, 8'h20);
    chk("uinv", {7'h0, out}, {7'h0, expo()});
    wr(ADDR_CTRL0, 8'h81);
    // Lower carrier inverted so a premature switch would show as a low
    wr(ADDR_CTRL1, 8'h12);
    // Status bit trails the pin by two flops
    repeat (2) @(posedge clk_i);
    rd(ADDR_CTRL0, 8'ha1, "status");
    wr(ADDR_CTRL0, 8'h80);
    repeat (6) begin
      chk("sync_hold", {7'h0, out}, 8'h01);
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    cu <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk("sync_switch", {7'h0, out}, {7'h0, expo()});
    @(posedge clk_i);
    cu <= 1'b1;
    wr(ADDR_CTRL0, 8'h81);
    chk("nosync", {7'h0, out}, {7'h0, expo()});
    wr(ADDR_CTRL0, 8'h11);
    chk("disabled", {7'h0, out}, 8'h00);
    rd(ADDR_SRC, 8'h01, "keep");
    wr(ADDR_CTRL0, 8'h81);
    chk("resume", {7'h0, out}, {7'h0, expo()});
    // Lower carrier with sync on; upper inverted so the two differ
    wr(ADDR_CTRL1, 8'h31);
    wr(ADDR_CTRL0, 8'h80);
    repeat (4) @(posedge clk_i);
    wr(ADDR_CTRL0, 8'h81);
    repeat (3) begin
      chk("lsync_hold", {7'h0, out}, 8'h01);
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    cu <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk("lsync_switch", {7'h0, out}, {7'h0, expo()});
    @(posedge clk_i);
    rst_i <= 1'b1;
    hold <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    sh = '{default: 8'h00};
    #1;
    chk("rst_out", {7'h0, out}, 8'h00);
    rd(ADDR_CTRL1, 8'h00, "rst_ctrl1");
    report_and_stop();
  end
endmodule
